// ---- bsw_pkg.sv ----
// package: constants and carriers for the burst sram write/select port
package bsw_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES  = 4;
    localparam int DATA_W = 36;

    // ------------------------------------------------------------
    // register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF       = 8'h00;
    localparam logic [7:0] STAT_OFF       = 8'h04;
    localparam logic [7:0] ADDR_OFF       = 8'h08;
    localparam int         CTRL_EN_BIT    = 0;
    localparam logic       CTRL_EN_RST    = 1'b1;
    localparam int         STAT_SEL_BIT   = 0;
    localparam int         STAT_CNT_LSB   = 1;
    localparam int         STAT_ORDER_BIT = 3;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LANE_W-1:0] lane_d_io;
        logic [LANE_W-1:0] lane_c_io;
        logic [LANE_W-1:0] lane_b_io;
        logic [LANE_W-1:0] lane_a_io;
    } bsw_lanes_s;

    typedef struct packed {
        logic [ADDR_W-3:0] addr_hi;
        logic              addr_bit1;
        logic              addr_bit0;
        bsw_lanes_s        data;
        logic              chip_enable_n;
        logic              chip_enable_high;
        logic              proc_addr_strobe_n;
        logic              ctrl_addr_strobe_n;
        logic              burst_step_n;
        logic [LANES-1:0]  lane_write_n;
        logic              byte_write_gate_n;
        logic              global_write_n;
        logic              burst_order_il;
    } bsw_pin_s;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } bsw_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } bsw_axi_rsp_s;

endpackage

// ---- bsw_mem.sv ----
// module: storage array with per-lane write and registered read
`timescale 1ns/1ps
module bsw_mem import bsw_pkg::*; (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic [LANES-1:0]  we,
    input  wire logic              rd,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdata_r
);

    // ------------------------------------------------------------
    // array, no reset: contents are undefined until written
    // ------------------------------------------------------------
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (we[i]) begin
                mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= '0;
        end else if (rd) begin
            rdata_r <= mem[addr];
        end
    end

endmodule

// ---- bsw_top.sv ----
// module: synchronous input port, burst counter and lane write select
//
// Contract
// - data bus is four lanes, lane a lowest through lane d highest.
// - every rising edge captures address, data, enables, write and burst pins.
// - in burst and wait cycles the two low address bits come from the counter.
// - each lane enable steers only its own lane.
// - lane enable low with gate low puts data pins in high impedance.
// - lane enables count only while the byte write gate is low.
// - global write low writes the full word regardless of gate and lane enables, except in a processor-strobe cycle.
// - low chip enable selects the device and qualifies the processor strobe.
// - high chip enable must be high for the device to be selected.
// - processor strobe with chip enable low loads address and starts a read.
// - controller strobe loads address, selects or deselects, then reads or writes.
// - burst step low advances the counter, high holds it for a wait cycle.
// - burst order pin low gives linear, high gives interleaved sequence.
`timescale 1ns/1ps
module bsw_top import bsw_pkg::*; (
    input  wire logic          sys_clk,
    input  wire logic          nrst,
    input  bsw_pin_s           pin_i,
    output bsw_lanes_s         lane_out,
    output logic [LANES-1:0]   lane_oe_n,
    input  bsw_axi_req_s       axi_req,
    output bsw_axi_rsp_s       axi_rsp
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        bsw_pin_s          pin;
        logic [ADDR_W-1:0] base;
        logic [1:0]        cnt;
        logic              sel;
        logic              rd_v;
        logic [LANES-1:0]  oe_n;
        logic [ADDR_W-1:0] last_addr;
        logic              ctrl_en;
        logic              aw_rdy;
        logic              w_rdy;
        logic              bvalid;
        logic [1:0]        bresp;
        logic [7:0]        aw_addr;
        logic              wd_en;
        logic              ws0;
        logic              ar_rdy;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
    } bsw_state_s;

    bsw_state_s        st_r;
    bsw_state_s        st_nxt;
    logic              p_start;
    logic              c_start;
    logic              cont;
    logic              acc;
    logic              axi_wr;
    logic [1:0]        low;
    logic [ADDR_W-1:0] acc_addr;
    logic [ADDR_W-1:0] ext_addr;
    logic [1:0]        ext_lo;
    logic [LANES-1:0]  wr_lanes;
    logic [LANES-1:0]  mem_we;
    logic              mem_rd;
    logic [DATA_W-1:0] mem_rdata;

    assign ext_addr = {st_r.pin.addr_hi, st_r.pin.addr_bit1,
                       st_r.pin.addr_bit0};
    assign ext_lo   = ext_addr[1:0];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        // every pin is registered; all decisions except the bus release below use the registered copy
        st_nxt.pin = pin_i;

        // processor strobe wins over controller strobe
        p_start = st_r.ctrl_en && !st_r.pin.proc_addr_strobe_n
                  && !st_r.pin.chip_enable_n;
        c_start = st_r.ctrl_en && !p_start
                  && !st_r.pin.ctrl_addr_strobe_n;
        cont    = st_r.ctrl_en && !p_start && !c_start && st_r.sel;

        if (p_start) begin
            st_nxt.base = ext_addr;
            st_nxt.cnt  = 2'h0;
            st_nxt.sel  = st_r.pin.chip_enable_high;
        end else if (c_start) begin
            st_nxt.base = ext_addr;
            st_nxt.cnt  = 2'h0;
            st_nxt.sel  = !st_r.pin.chip_enable_n
                          && st_r.pin.chip_enable_high;
        end else if (!st_r.ctrl_en) begin
            st_nxt.sel = 1'b0;
        end else if (cont && !st_r.pin.burst_step_n) begin
            st_nxt.cnt = st_r.cnt + 2'h1;
        end

        // low bits never come from the pins once a burst is under way
        if (st_r.pin.burst_order_il) begin
            low = st_nxt.base[1:0] ^ st_nxt.cnt;
        end else begin
            low = st_nxt.base[1:0] + st_nxt.cnt;
        end
        acc_addr = {st_nxt.base[ADDR_W-1:2], low};
        acc      = st_nxt.sel && (p_start || c_start || cont);

        for (int i = 0; i < LANES; i++) begin
            wr_lanes[i] = !st_r.pin.global_write_n
                          || (!st_r.pin.byte_write_gate_n
                              && !st_r.pin.lane_write_n[i]);
        end
        // a processor-strobe cycle never writes
        mem_we = (acc && !p_start) ? wr_lanes : '0;
        mem_rd = acc && (mem_we == '0);

        st_nxt.rd_v = mem_rd;
        st_nxt.oe_n = {LANES{!mem_rd}};
        // release the bus as soon as the controller signals a gated lane write
        if (!pin_i.byte_write_gate_n && (pin_i.lane_write_n != '1)) begin
            st_nxt.oe_n = '1;
        end
        if (acc) begin
            st_nxt.last_addr = acc_addr;
        end

        // register bus: address and data taken in either order
        axi_wr = !st_r.aw_rdy && !st_r.w_rdy && !st_r.bvalid;
        if (axi_req.awvalid && st_r.aw_rdy) begin
            st_nxt.aw_rdy  = 1'b0;
            st_nxt.aw_addr = axi_req.awaddr[7:0];
        end
        if (axi_req.wvalid && st_r.w_rdy) begin
            st_nxt.w_rdy = 1'b0;
            st_nxt.wd_en = axi_req.wdata[CTRL_EN_BIT];
            st_nxt.ws0   = axi_req.wstrb[0];
        end
        if (axi_wr) begin
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = RESP_OKAY;
            if (st_r.aw_addr == CTRL_OFF) begin
                if (st_r.ws0) begin
                    st_nxt.ctrl_en = st_r.wd_en;
                end
            end else if (st_r.aw_addr != STAT_OFF
                         && st_r.aw_addr != ADDR_OFF) begin
                st_nxt.bresp = RESP_SLVERR;
            end
        end
        if (st_r.bvalid && axi_req.bready) begin
            st_nxt.bvalid = 1'b0;
            st_nxt.aw_rdy = 1'b1;
            st_nxt.w_rdy  = 1'b1;
        end
        if (axi_req.arvalid && st_r.ar_rdy) begin
            st_nxt.ar_rdy = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = RESP_OKAY;
            st_nxt.rdata  = '0;
            case (axi_req.araddr[7:0])
                CTRL_OFF: begin
                    st_nxt.rdata[CTRL_EN_BIT] = st_r.ctrl_en;
                end
                STAT_OFF: begin
                    st_nxt.rdata[STAT_SEL_BIT]      = st_r.sel;
                    st_nxt.rdata[STAT_CNT_LSB +: 2] = st_r.cnt;
                    st_nxt.rdata[STAT_ORDER_BIT]    =
                        st_r.pin.burst_order_il;
                end
                ADDR_OFF: begin
                    st_nxt.rdata[ADDR_W-1:0] = st_r.last_addr;
                end
                default: begin
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st_r.rvalid && axi_req.rready) begin
            st_nxt.rvalid = 1'b0;
            st_nxt.ar_rdy = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r         <= '0;
            st_r.pin     <= '1;
            st_r.oe_n    <= '1;
            st_r.ctrl_en <= CTRL_EN_RST;
            st_r.aw_rdy  <= 1'b1;
            st_r.w_rdy   <= 1'b1;
            st_r.ar_rdy  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // array and outputs
    // ------------------------------------------------------------
    bsw_mem u_mem (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .we      (mem_we),
        .rd      (mem_rd),
        .addr    (acc_addr),
        .wdata   (st_r.pin.data),
        .rdata_r (mem_rdata)
    );

    // lane a sits in the lowest bits of the word
    assign lane_out         = bsw_lanes_s'(mem_rdata);
    assign lane_oe_n        = st_r.oe_n;
    assign axi_rsp.awready  = st_r.aw_rdy;
    assign axi_rsp.wready   = st_r.w_rdy;
    assign axi_rsp.bresp    = st_r.bresp;
    assign axi_rsp.bvalid   = st_r.bvalid;
    assign axi_rsp.arready  = st_r.ar_rdy;
    assign axi_rsp.rdata    = st_r.rdata;
    assign axi_rsp.rresp    = st_r.rresp;
    assign axi_rsp.rvalid   = st_r.rvalid;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence proc_go;
        p_start && st_r.pin.chip_enable_high;
    endsequence
    sequence ctrl_go;
        c_start && !st_r.pin.chip_enable_n && st_r.pin.chip_enable_high;
    endsequence
    sequence step_on;
        cont && !st_r.pin.burst_step_n;
    endsequence

    pin_capture_a: assert property (
        $past(nrst) |-> st_r.pin == $past(pin_i))
        else $error("pins not captured");
    burst_upper_a: assert property (
        cont |-> acc_addr[ADDR_W-1:2] == st_r.base[ADDR_W-1:2])
        else $error("burst changed upper address");
    lane_only_a: assert property (
        (acc && !p_start && st_r.pin.global_write_n
         && !st_r.pin.byte_write_gate_n)
        |-> mem_we == ~st_r.pin.lane_write_n)
        else $error("lane write crossed lanes");
    write_hiz_a: assert property (
        (!pin_i.byte_write_gate_n && pin_i.lane_write_n != '1)
        |=> lane_oe_n == '1)
        else $error("data driven during write");
    gate_off_a: assert property (
        (st_r.pin.byte_write_gate_n && st_r.pin.global_write_n)
        |-> mem_we == '0)
        else $error("lane write without gate");
    global_all_a: assert property (
        (acc && !p_start && !st_r.pin.global_write_n) |-> mem_we == '1)
        else $error("global write not full word");
    ce_gate_a: assert property (
        (st_r.pin.chip_enable_n && !st_r.pin.proc_addr_strobe_n
         && st_r.pin.ctrl_addr_strobe_n)
        |=> st_r.base == $past(st_r.base))
        else $error("proc strobe taken while disabled");
    ce_high_a: assert property (
        ((p_start || c_start) && !st_r.pin.chip_enable_high) |=> !st_r.sel)
        else $error("selected with high enable low");
    proc_read_a: assert property (
        proc_go |-> mem_we == '0 ##1 (st_r.rd_v
                                     && st_r.base == $past(ext_addr)))
        else $error("proc strobe did not start read");
    ctrl_sel_a: assert property (
        ctrl_go |=> st_r.sel && st_r.base == $past(ext_addr))
        else $error("ctrl strobe did not select");
    wait_hold_a: assert property (
        (cont && st_r.pin.burst_step_n) |=> st_r.cnt == $past(st_r.cnt))
        else $error("counter moved in wait cycle");
    order_lin_a: assert property (
        ctrl_go ##1 (step_on and !st_r.pin.burst_order_il)
        |-> acc_addr[1:0] == $past(ext_lo) + 2'h1)
        else $error("linear sequence wrong");
    order_il_a: assert property (
        proc_go ##1 (step_on and st_r.pin.burst_order_il)
        |-> acc_addr[1:0] == ($past(ext_lo) ^ 2'h1))
        else $error("interleaved sequence wrong");
    read_path_a: assert property (
        (acc && mem_we == '0) |=> st_r.rd_v ##0 (lane_oe_n == '0
            || (!$past(pin_i.byte_write_gate_n)
                && $past(pin_i.lane_write_n) != '1))
        )
        else $error("read not issued");

endmodule

// ---- bsw_ctrl_model.sv ----
// partner model: external controller driving the synchronous sram pins
`timescale 1ns/1ps
module bsw_ctrl_model import bsw_pkg::*; (
    input  wire logic sys_clk,
    output bsw_pin_s  pin_o
);
    // ------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------
    initial begin
        pin_o = '1;
        pin_o.data = '0;
    end

    // s = {proc strobe, ctrl strobe, step, ce low, ce high}; g = {gw, gate}
    task automatic drive(input logic [4:0]  s,
                         input logic [17:0] a,
                         input logic [1:0]  g,
                         input logic [3:0]  lw,
                         input logic [35:0] d,
                         input logic        il);
        logic wr;
        wr = !g[1] || (!g[0] && lw != 4'hf);
        @(posedge sys_clk);
        pin_o.proc_addr_strobe_n <= s[4];
        pin_o.ctrl_addr_strobe_n <= s[3];
        pin_o.burst_step_n       <= s[2];
        pin_o.chip_enable_n      <= s[1];
        pin_o.chip_enable_high   <= s[0];
        pin_o.global_write_n     <= g[1];
        pin_o.byte_write_gate_n  <= g[0];
        pin_o.lane_write_n       <= lw;
        pin_o.burst_order_il     <= il;
        // address only means something with a strobe: junk otherwise
        {pin_o.addr_hi, pin_o.addr_bit1, pin_o.addr_bit0} <=
            (!s[4] || !s[3]) ? a : ~a;
        // a released data bus shows the inverse of its last value
        pin_o.data <= wr ? d : ~pin_o.data;
    endtask
endmodule

// ---- tb.sv ----
// testbench: pin port, burst counter and register access of bsw_top
`timescale 1ns/1ps
module tb import bsw_pkg::*;;
    logic         sys_clk;
    logic         nrst;
    bsw_pin_s     pins;
    bsw_lanes_s   lane_out;
    logic [3:0]   lane_oe_n;
    bsw_axi_req_s areq;
    bsw_axi_rsp_s arsp;
    int           mismatches;
    int           samples_checked;
    logic         il, en_ref, sel;
    logic [17:0]  base, last;
    logic [1:0]   cnt, k0, k1, k2;
    logic         f0, f1;
    logic [35:0]  d0, d1, d2;
    logic [35:0]  mem [logic [17:0]];

    bsw_top i_bsw_top (.sys_clk(sys_clk), .nrst(nrst), .pin_i(pins),
        .lane_out(lane_out), .lane_oe_n(lane_oe_n), .axi_req(areq),
        .axi_rsp(arsp));
    bsw_ctrl_model i_bsw_ctrl_model (.sys_clk(sys_clk), .pin_o(pins));

    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [35:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // answer of an access shows two edges after it is driven
    always @(posedge sys_clk) begin
        {k1, d1} <= {k0, d0};
        {k2, d2} <= {k1, d1};
        f1 <= f0;
    end

    // a gated lane write releases the bus one cycle ahead of its own access
    always @(negedge sys_clk) begin
        if (nrst && k2 != 2'd0) begin
            chk("lane_oe_n", (k2 == 2'd2 || f1) ? 36'hf : 36'h0,
                {32'h0, lane_oe_n});
            if (k2 == 2'd1) chk("lane_out", d2, lane_out);
        end
    end

    // ------------------------------------------------------------
    // pin cycle with reference model
    // ------------------------------------------------------------
    task automatic cyc(input logic [4:0] s, input logic [17:0] a,
                       input logic [1:0] g, input logic [3:0] lw,
                       input logic [35:0] d);
        logic [3:0]  we;
        logic [17:0] ad;
        logic [1:0]  k;
        we = 4'h0;
        k = 2'd2;
        if (!en_ref) sel = 1'b0;
        else if (!s[4] && !s[1]) {sel, base, cnt} = {s[0], a, 2'h0};
        else if (!s[3]) {sel, base, cnt} = {!s[1] && s[0], a, 2'h0};
        else if (!s[2]) cnt = cnt + 2'h1;
        ad = {base[17:2], il ? base[1:0] ^ cnt : base[1:0] + cnt};
        if (sel) begin
            last = ad;
            for (int i = 0; i < 4; i++) begin
                // a processor-strobe cycle never writes
                we[i] = (s[4] || s[1]) && (!g[1] || (!g[0] && !lw[i]));
                if (we[i]) mem[ad][i*9 +: 9] = d[i*9 +: 9];
            end
            if (we == 4'h0) k = mem.exists(ad) ? 2'd1 : 2'd3;
        end
        i_bsw_ctrl_model.drive(s, a, g, lw, d, il);
        k0 <= k;
        f0 <= !g[0] && lw != 4'hf;
        d0 <= mem.exists(ad) ? mem[ad] : 36'h0;
    endtask

    task automatic idle;
        cyc(5'b10111, 18'h0, 2'b11, 4'hf, '0);
    endtask

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    // responses are looked at settled, half a cycle before the edge
    task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
        logic       done;
        logic [1:0] hs;
        logic [1:0] br;
        done = 1'b0;
        @(posedge sys_clk);
        areq.awaddr <= a;
        areq.wdata <= d;
        areq.wstrb <= 4'hf;
        {areq.awvalid, areq.wvalid, areq.bready} <= 3'b111;
        while (!done) begin
            @(negedge sys_clk);
            hs = {areq.awvalid && arsp.awready, areq.wvalid && arsp.wready};
            done = arsp.bvalid;
            br = arsp.bresp;
            @(posedge sys_clk);
            if (hs[1]) areq.awvalid <= 1'b0;
            if (hs[0]) areq.wvalid <= 1'b0;
        end
        areq.bready <= 1'b0;
        chk("bresp", {34'h0, er}, {34'h0, br});
    endtask

    task automatic areg(input logic [31:0] a, exp, msk, input logic [1:0] er);
        logic        done;
        logic        ar_hs;
        logic [31:0] rd;
        logic [1:0]  rr;
        done = 1'b0;
        @(posedge sys_clk);
        areq.araddr <= a;
        {areq.arvalid, areq.rready} <= 2'b11;
        while (!done) begin
            @(negedge sys_clk);
            ar_hs = areq.arvalid && arsp.arready;
            done = arsp.rvalid;
            rd = arsp.rdata;
            rr = arsp.rresp;
            @(posedge sys_clk);
            if (ar_hs) areq.arvalid <= 1'b0;
        end
        areq.rready <= 1'b0;
        chk("rdata", {4'h0, exp & msk}, {4'h0, rd & msk});
        chk("rresp", {34'h0, er}, {34'h0, rr});
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        $display("[ERR] watchdog expected done seen hang");
        results();
    end

    initial begin
        {areq, nrst, il, en_ref, sel} = '0;
        {base, last, cnt, k0, d0, f0} = '0;
        en_ref = 1'b1;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        chk("lane_oe_n", 36'hf, {32'h0, lane_oe_n});
        areg({24'h0, CTRL_OFF}, 32'h1, 32'h1, RESP_OKAY);
        areg(32'h0c, 32'h0, '1, RESP_SLVERR);
        axi_wr(32'h10, 32'h1, RESP_SLVERR);
        $display("test reset done");
        // linear write burst, wait cycle at step two, wraps low bits
        for (int i = 0; i < 5; i++)
            cyc({1'b1, i != 0, i == 2, 2'b01}, 18'h00106, 2'b01, 4'hf,
                36'h123456789 + i * 36'h010203041);
        idle();
        il = 1'b1;
        cyc(5'b01101, 18'h00107, 2'b01, 4'hf, '0);
        for (int i = 0; i < 3; i++)
            cyc(5'b11001, 18'h00107, 2'b11, 4'hf, '0);
        idle();
        $display("test burst done");
        cyc(5'b10101, 18'h00104, 2'b10, 4'b1010, '1);
        cyc(5'b11101, 18'h00104, 2'b11, 4'b0000, '0);
        cyc(5'b11101, 18'h00104, 2'b10, 4'b0111, '0);
        cyc(5'b11101, 18'h00104, 2'b11, 4'hf, '0);
        idle();
        $display("test lanes done");
        cyc(5'b01111, 18'h00105, 2'b11, 4'hf, '0);
        cyc(5'b10100, 18'h00105, 2'b11, 4'hf, '0);
        cyc(5'b10111, 18'h00105, 2'b11, 4'hf, '0);
        cyc(5'b10101, 18'h00105, 2'b11, 4'hf, '0);
        idle();
        $display("test select done");
        axi_wr({24'h0, CTRL_OFF}, 32'h0, RESP_OKAY);
        en_ref = 1'b0;
        cyc(5'b10101, 18'h00106, 2'b11, 4'hf, '0);
        idle();
        axi_wr({24'h0, CTRL_OFF}, 32'h1, RESP_OKAY);
        en_ref = 1'b1;
        areg({24'h0, ADDR_OFF}, {14'h0, last}, 32'h3ffff, RESP_OKAY);
        areg({24'h0, STAT_OFF}, {28'h0, il, 3'h0}, 32'h9, RESP_OKAY);
        repeat (3) @(posedge sys_clk);
        $display("test registers done");
        results();
    end
endmodule
